// ===== verilog/fhd_pkg.sv
// Purpose: Shared constants and types for the host DMA engine of the ring network port
// Assumes: One clock, synchronous active-high reset, 8-bit host register path
// Notes: Byte lane 0 carries bits 31:24 of a register, lane 3 bits 7:0
package fhd_pkg;
  typedef logic [31:0] fhd_word_t;
  typedef logic [11:0] fhd_cnt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_G, ST_WAIT_D} fhd_state_t;

  // --------------------------------------------------
  // Register locations
  // --------------------------------------------------
  localparam fhd_word_t A_ADDR1 = 32'hF803130C;
  localparam fhd_word_t A_WC1 = 32'hF8031310;
  localparam fhd_word_t A_ADDR2 = 32'hF8031314;
  localparam fhd_word_t A_WC2 = 32'hF8031318;
  localparam fhd_word_t A_CLAIM = 32'hF803131C;
  localparam fhd_word_t A_CTRL = 32'hF8031320;
  localparam fhd_word_t A_STAT = 32'hF8031324;
  localparam fhd_word_t A_CAUSE = 32'hF8031328;
  localparam fhd_word_t A_MASK = 32'hF803132C;
  localparam fhd_word_t A_SRST = 32'hF8031330;
  localparam fhd_word_t A_SUM = 32'hF0EB1400;
  localparam fhd_word_t A_OVL_LO = 32'hF803131C;
  localparam fhd_word_t A_OVL_HI = 32'hF8031328;

  // --------------------------------------------------
  // Field positions and codes
  // --------------------------------------------------
  localparam int B_SUM_EN = 2;
  localparam int B_ZERO2 = 3;
  localparam int B_OWN_LO = 4;
  localparam int B_ARMED = 6;
  localparam int B_OVL_OWN = 13;
  localparam int B_OVL_ARM = 15;
  localparam logic [1:0] OWN_FREE = 2'h0;
  localparam logic [1:0] OWN_TX = 2'h1;
  localparam logic [1:0] OWN_RX = 2'h2;
  localparam logic [1:0] OWN_FREE2 = 2'h3;
  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_SYNC = 2'h2;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam fhd_word_t WORD_STEP = 32'h00000004;

  // --------------------------------------------------
  // Reset values and buffer shape
  // --------------------------------------------------
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [4:0] SYNC_RST = 5'h07;
  localparam int FIFO_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] RX_STOP_LVL = 5'h0E;
  localparam logic [4:0] TX_FULL_LVL = 5'h10;
endpackage

// ===== verilog/fhd_dma.sv
// Purpose: Host DMA engine between the controller buffer port and system memory
// Assumes: Buffer port and memory port run on sys_clk; interrupt and frame pins are async
// Notes: Leftover buffered words are flushed only by rst or by a subsystem reset
`timescale 1ns/10ps

module fhd_fifo
#(
  parameter int W = 32,
  parameter int DEPTH = 16
)
(
  // Clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // --------------------------------------------------
  // Pointer arithmetic
  // --------------------------------------------------
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || (ce && flush))
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (ce && push)
      mem_r[wp_r] <= in_data;
  end

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign level = cnt_r;
endmodule

module fhd_dma
(
  // Clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Host byte path
  input wire fhd_pkg::fhd_word_t host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  // Controller pins
  input wire logic controller_irq_line_a_n,
  input wire logic controller_irq_line_b_n,
  input wire logic phy_irq_line_n,
  input wire logic rx_pending,
  input wire logic frame_end_signal,
  output logic [1:0] service_request_code,
  output logic multicast_enable,
  output logic host_irq,
  output logic subsystem_reset_out,
  // Controller buffer port
  input wire fhd_pkg::fhd_word_t buf_rx_data,
  input wire logic buf_rx_valid,
  output logic buf_rx_ready,
  output fhd_pkg::fhd_word_t buf_tx_data,
  output logic buf_tx_valid,
  input wire logic buf_tx_ready,
  // Memory master
  output logic mem_req,
  output logic mem_we,
  output fhd_pkg::fhd_word_t mem_addr,
  output fhd_pkg::fhd_word_t mem_wdata,
  input wire logic mem_gnt,
  input wire fhd_pkg::fhd_word_t mem_rdata,
  input wire logic mem_rvalid
);
  import fhd_pkg::*;

  function automatic logic [7:0] lane_byte(input fhd_word_t w, input logic [1:0] lane);
    logic [7:0] b;
    b = w[31:24];
    case (lane)
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
      default: b = w[31:24];
    endcase
    return b;
  endfunction

  // --------------------------------------------------
  // State
  // --------------------------------------------------
  logic [4:0] s1_r, s2_r, s2_nxt;
  logic fe_d_r, fe_d_nxt;
  fhd_word_t addr1_r, addr1_nxt, addr2_r, addr2_nxt;
  fhd_cnt_t wc1_r, wc1_nxt, wc2_r, wc2_nxt;
  logic [1:0] code_r, code_nxt, owner_r, owner_nxt;
  logic sum_en_r, sum_en_nxt, armed_r, armed_nxt;
  logic busy_r, busy_nxt, set2_r, set2_nxt;
  fhd_state_t st_r, st_nxt;
  fhd_word_t sum_r, sum_nxt, snap_r, snap_nxt;
  logic fe_seen_r, fe_seen_nxt, done_r, done_nxt;
  logic [5:0] mask_r, mask_nxt;
  logic [23:0] hold_r, hold_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic srst_r, srst_nxt, irq_r, irq_nxt, rx_ready_r, rx_ready_nxt;
  fhd_word_t tx_data_r, tx_data_nxt, mem_addr_r, mem_addr_nxt, mem_wdata_r, mem_wdata_nxt;
  logic tx_valid_r, tx_valid_nxt, mem_req_r, mem_req_nxt, mem_we_r, mem_we_nxt;

  // Working signals
  fhd_word_t word_a, rv, wv, fifo_in_data, fifo_out_data;
  logic [1:0] lane, claim_owner;
  logic [4:0] cause, fifo_level;
  logic free, both_zero, rx_mode, tx_take, eng_pop, eng_push;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  fhd_cnt_t act_wc;

  fhd_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .flush(srst_r),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .level(fifo_level)
  );

  // --------------------------------------------------
  // Next-state logic
  // --------------------------------------------------
  always_comb
  begin
    s2_nxt = s1_r;
    fe_d_nxt = s2_r[4];
    addr1_nxt = addr1_r;
    addr2_nxt = addr2_r;
    wc1_nxt = wc1_r;
    wc2_nxt = wc2_r;
    code_nxt = code_r;
    owner_nxt = owner_r;
    sum_en_nxt = sum_en_r;
    armed_nxt = armed_r;
    busy_nxt = busy_r;
    set2_nxt = set2_r;
    st_nxt = st_r;
    sum_nxt = sum_r;
    snap_nxt = snap_r;
    fe_seen_nxt = fe_seen_r;
    done_nxt = done_r;
    mask_nxt = mask_r;
    hold_nxt = hold_r;
    rdata_nxt = rdata_r;
    srst_nxt = 1'b0;
    tx_data_nxt = tx_data_r;
    tx_valid_nxt = tx_valid_r;
    mem_req_nxt = mem_req_r;
    mem_we_nxt = mem_we_r;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    eng_pop = 1'b0;
    eng_push = 1'b0;

    word_a = {host_addr[31:2], 2'h0};
    lane = host_addr[1:0];
    free = (owner_r == OWN_FREE) || (owner_r == OWN_FREE2);
    claim_owner = free ? OWN_TX : owner_r;
    both_zero = (wc1_r == '0) && (wc2_r == '0);
    cause = {done_r, s2_r[3], ~s2_r[2], ~s2_r[1], ~s2_r[0]};
    rx_mode = (owner_r == OWN_RX);
    act_wc = set2_r ? wc2_r : wc1_r;

    // Register read value; status bits above 1 read as zero except the owner and armed overlay in bits 15:13
    case (word_a)
      A_ADDR1: rv = addr1_r;
      A_WC1: rv = {20'h00000, wc1_r};
      A_ADDR2: rv = addr2_r;
      A_WC2: rv = {20'h00000, wc2_r};
      A_CTRL: rv = {25'h0000000, armed_r, owner_r, 1'b0, sum_en_r, code_r};
      A_STAT: rv = {30'h00000000, fe_seen_r, both_zero};
      A_CAUSE: rv = {27'h0000000, cause};
      A_MASK: rv = {26'h0000000, mask_r};
      A_SUM: rv = sum_r;
      default: rv = 32'h00000000;
    endcase
    if (word_a >= A_OVL_LO && word_a <= A_OVL_HI)
    begin
      rv[B_OVL_OWN +: 2] = (word_a == A_CLAIM) ? claim_owner : owner_r;
      rv[B_OVL_ARM] = (word_a == A_CLAIM && free) ? 1'b0 : armed_r;
    end

    // Byte passing: lane 0 read snapshots the word and takes the side effects
    if (host_rd)
    begin
      if (lane == 2'h0)
      begin
        snap_nxt = rv;
        rdata_nxt = rv[31:24];
        if (word_a == A_CLAIM && free)
        begin
          owner_nxt = OWN_TX;
          armed_nxt = 1'b0;
        end
        if (word_a == A_SUM)
        begin
          sum_nxt = 32'h00000000;
          fe_seen_nxt = 1'b0;
        end
        if (word_a == A_CAUSE)
          done_nxt = 1'b0;
      end
      else
        rdata_nxt = lane_byte(snap_r, lane);
    end

    // Lanes 0-2 are held, lane 3 commits the whole word
    wv = {hold_r, host_wdata};
    if (host_wr)
    begin
      if (word_a == A_SRST)
        srst_nxt = 1'b1;
      case (lane)
        2'h0: hold_nxt[23:16] = host_wdata;
        2'h1: hold_nxt[15:8] = host_wdata;
        2'h2: hold_nxt[7:0] = host_wdata;
        default: hold_nxt = hold_r;
      endcase
      if (lane == LANE_LAST)
      begin
        case (word_a)
          A_ADDR1: addr1_nxt = wv;
          A_WC1: wc1_nxt = wv[11:0];
          A_ADDR2: addr2_nxt = wv;
          A_WC2: wc2_nxt = wv[11:0];
          A_MASK: mask_nxt = wv[5:0];
          A_CTRL:
          begin
            code_nxt = wv[1:0];
            sum_en_nxt = wv[B_SUM_EN];
            owner_nxt = wv[B_OWN_LO +: 2];
            armed_nxt = wv[B_ARMED];
            if (wv[B_ZERO2])
            begin
              addr2_nxt = 32'h00000000;
              wc2_nxt = 12'h000;
            end
            if (wv[1:0] != REQ_NONE)
            begin
              busy_nxt = 1'b1;
              set2_nxt = 1'b0;
            end
          end
          default: wc1_nxt = wc1_nxt;
        endcase
      end
    end

    // Automatic receive start when armed and the engine is free
    // Any host access that cycle blocks it, so a claim read never loses the engine
    if (s2_r[3] && armed_r && free && !busy_r && !host_wr && !host_rd)
    begin
      owner_nxt = OWN_RX;
      code_nxt = REQ_SYNC;
      busy_nxt = 1'b1;
      set2_nxt = 1'b0;
    end

    // Engine: one word in flight; direction follows the owner bits
    case (st_r)
      ST_IDLE:
      begin
        if (busy_r)
        begin
          if (act_wc == '0)
          begin
            if (!set2_r && wc2_r != '0)
              set2_nxt = 1'b1;
            else
            begin
              busy_nxt = 1'b0;
              code_nxt = REQ_NONE;
              done_nxt = 1'b1;
            end
          end
          else if (rx_mode && fifo_out_valid)
          begin
            eng_pop = 1'b1;
            mem_req_nxt = 1'b1;
            mem_we_nxt = 1'b1;
            mem_addr_nxt = set2_r ? addr2_r : addr1_r;
            mem_wdata_nxt = fifo_out_data;
            st_nxt = ST_WAIT_G;
          end
          else if (!rx_mode && fifo_level < TX_FULL_LVL)
          begin
            mem_req_nxt = 1'b1;
            mem_we_nxt = 1'b0;
            mem_addr_nxt = set2_r ? addr2_r : addr1_r;
            st_nxt = ST_WAIT_G;
          end
        end
      end
      ST_WAIT_G:
      begin
        if (mem_gnt)
        begin
          mem_req_nxt = 1'b0;
          if (set2_r)
          begin
            addr2_nxt = addr2_r + WORD_STEP;
            wc2_nxt = wc2_r - 12'h001;
          end
          else
          begin
            addr1_nxt = addr1_r + WORD_STEP;
            wc1_nxt = wc1_r - 12'h001;
          end
          if (mem_we_r && sum_en_r)
            sum_nxt = sum_nxt + mem_wdata_r;
          st_nxt = mem_we_r ? ST_IDLE : ST_WAIT_D;
        end
      end
      ST_WAIT_D:
      begin
        if (mem_rvalid)
        begin
          eng_push = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase

    // Edge of frame end wins over a same-cycle clear
    if (s2_r[4] && !fe_d_r)
      fe_seen_nxt = 1'b1;

    // Outbound output stage
    tx_take = !tx_valid_r || buf_tx_ready;
    if (!rx_mode && tx_take && fifo_out_valid)
    begin
      tx_data_nxt = fifo_out_data;
      tx_valid_nxt = 1'b1;
    end
    else if (buf_tx_ready)
      tx_valid_nxt = 1'b0;

    // Two words of slack cover the registered ready
    rx_ready_nxt = busy_nxt && (owner_nxt == OWN_RX) && (fifo_level < RX_STOP_LVL);
    irq_nxt = |(cause & mask_r[4:0]);

    fifo_in_data = rx_mode ? buf_rx_data : mem_rdata;
    fifo_in_valid = rx_mode ? (buf_rx_valid && rx_ready_r) : eng_push;
    fifo_out_ready = rx_mode ? eng_pop : tx_take;
  end

  // --------------------------------------------------
  // Registers
  // --------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst || (ce && srst_r))
    begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      fe_d_r <= 1'b0;
      addr1_r <= '0;
      addr2_r <= '0;
      wc1_r <= '0;
      wc2_r <= '0;
      code_r <= REQ_NONE;
      owner_r <= OWN_FREE;
      sum_en_r <= 1'b0;
      armed_r <= 1'b0;
      busy_r <= 1'b0;
      set2_r <= 1'b0;
      st_r <= ST_IDLE;
      sum_r <= '0;
      snap_r <= '0;
      fe_seen_r <= 1'b0;
      done_r <= 1'b0;
      mask_r <= MASK_RST;
      hold_r <= '0;
      rdata_r <= 8'h00;
      srst_r <= 1'b0;
      irq_r <= 1'b0;
      rx_ready_r <= 1'b0;
      tx_data_r <= '0;
      tx_valid_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= '0;
    end
    else if (ce)
    begin
      s1_r <= {frame_end_signal, rx_pending, phy_irq_line_n, controller_irq_line_b_n, controller_irq_line_a_n};
      s2_r <= s2_nxt;
      fe_d_r <= fe_d_nxt;
      addr1_r <= addr1_nxt;
      addr2_r <= addr2_nxt;
      wc1_r <= wc1_nxt;
      wc2_r <= wc2_nxt;
      code_r <= code_nxt;
      owner_r <= owner_nxt;
      sum_en_r <= sum_en_nxt;
      armed_r <= armed_nxt;
      busy_r <= busy_nxt;
      set2_r <= set2_nxt;
      st_r <= st_nxt;
      sum_r <= sum_nxt;
      snap_r <= snap_nxt;
      fe_seen_r <= fe_seen_nxt;
      done_r <= done_nxt;
      mask_r <= mask_nxt;
      hold_r <= hold_nxt;
      rdata_r <= rdata_nxt;
      srst_r <= srst_nxt;
      irq_r <= irq_nxt;
      rx_ready_r <= rx_ready_nxt;
      tx_data_r <= tx_data_nxt;
      tx_valid_r <= tx_valid_nxt;
      mem_req_r <= mem_req_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  assign host_rdata = rdata_r;
  assign service_request_code = code_r;
  assign multicast_enable = mask_r[5];
  assign host_irq = irq_r;
  assign subsystem_reset_out = srst_r;
  assign buf_rx_ready = rx_ready_r;
  assign buf_tx_data = tx_data_r;
  assign buf_tx_valid = tx_valid_r;
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
endmodule

// ===== test/fhd_dma_props.sv
// Purpose: Port-level checks for the host DMA engine
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached to fhd_dma by bind at the foot of this file
`timescale 1ns/10ps
module fhd_dma_props
(
  // Clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Host byte path
  input wire fhd_pkg::fhd_word_t host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata,
  // Controller side
  input wire logic [1:0] service_request_code,
  input wire logic multicast_enable,
  input wire logic host_irq,
  input wire logic subsystem_reset_out,
  input wire fhd_pkg::fhd_word_t buf_tx_data,
  input wire logic buf_tx_valid,
  input wire logic buf_tx_ready,
  // Memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire fhd_pkg::fhd_word_t mem_addr,
  input wire logic mem_gnt
);
  import fhd_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst_quiet;
    $fell(rst) |-> service_request_code == REQ_NONE && !mem_req && !host_irq && !multicast_enable;
  endproperty
  property p_srst_cause;
    ce && host_wr && host_addr == A_SRST |=> subsystem_reset_out;
  endproperty
  property p_srst_effect;
    subsystem_reset_out |=> !subsystem_reset_out && service_request_code == REQ_NONE && !multicast_enable;
  endproperty
  property p_wr_code;
    mem_req && mem_we |-> service_request_code == REQ_SYNC;
  endproperty
  property p_req_code;
    mem_req |-> service_request_code != REQ_NONE;
  endproperty
  property p_req_hold;
    mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  property p_tx_hold;
    buf_tx_valid && !buf_tx_ready |=> buf_tx_valid && $stable(buf_tx_data);
  endproperty
  property p_unmapped;
    ce && host_rd && host_addr == 32'hF8031340 |=> host_rdata == 8'h00;
  endproperty
  property p_claim;
    ce && host_rd && host_addr == A_CLAIM + 32'h2 |=> host_rdata[6:5] != 2'h0;
  endproperty
  property p_mcast;
    ce && host_wr && host_addr == A_MASK + 32'h3 |-> ##2 multicast_enable == $past(host_wdata[5], 2);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  a_srst_cause: assert property (p_srst_cause) else $error("no soft reset pulse");
  a_srst_effect: assert property (p_srst_effect) else $error("soft reset left state");
  a_wr_code: assert property (p_wr_code) else $error("memory write outside receive");
  a_req_code: assert property (p_req_code) else $error("memory request with no code");
  a_req_hold: assert property (p_req_hold) else $error("request changed before grant");
  a_tx_hold: assert property (p_tx_hold) else $error("outbound word changed while stalled");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_claim: assert property (p_claim) else $error("owner read as free");
  a_mcast: assert property (p_mcast) else $error("multicast enable wrong");
  c_rx: cover property (mem_req && mem_gnt && mem_we);
  c_tx: cover property (buf_tx_valid && buf_tx_ready);
  c_srst: cover property (subsystem_reset_out);
endmodule

bind fhd_dma fhd_dma_props u_props (.sys_clk(sys_clk), .rst(rst), .ce(ce), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
  .service_request_code(service_request_code), .multicast_enable(multicast_enable), .host_irq(host_irq),
  .subsystem_reset_out(subsystem_reset_out), .buf_tx_data(buf_tx_data), .buf_tx_valid(buf_tx_valid),
  .buf_tx_ready(buf_tx_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_gnt(mem_gnt));

// ===== test/fhd_partner.sv
// Purpose: Memory slave and controller buffer port facing the engine
// Assumes: Read data is the address xor a fixed pattern
// Notes: Random stalls; released data lines show inverted junk
`timescale 1ns/10ps
module fhd_partner
(
  // Clocking
  input wire logic sys_clk,
  input wire logic rst,
  // Memory slave
  input wire logic mem_req,
  input wire logic mem_we,
  input wire fhd_pkg::fhd_word_t mem_addr,
  output logic mem_gnt,
  output fhd_pkg::fhd_word_t mem_rdata,
  output logic mem_rvalid,
  // Buffer port
  output fhd_pkg::fhd_word_t buf_rx_data,
  output logic buf_rx_valid,
  input wire logic buf_rx_ready,
  output logic buf_tx_ready
);
  import fhd_pkg::*;
  fhd_word_t rx_cnt = 32'h0;
  logic nv;
  initial
  begin
    mem_gnt = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata = 32'h0;
    buf_rx_valid = 1'b0;
    buf_rx_data = 32'h0;
    buf_tx_ready = 1'b0;
  end
  always @(posedge sys_clk)
  begin
    mem_gnt <= !rst && mem_req && !mem_gnt && ($urandom % 3 != 0);
    mem_rvalid <= mem_req && mem_gnt && !mem_we;
    mem_rdata <= (mem_req && mem_gnt && !mem_we) ? (mem_addr ^ 32'hA5A50000) : ~mem_rdata;
    buf_tx_ready <= $urandom % 2;
    if (buf_rx_valid && buf_rx_ready)
      rx_cnt <= rx_cnt + 32'h1;
    if (!buf_rx_valid || buf_rx_ready)
    begin
      nv = ($urandom % 4 != 0);
      buf_rx_valid <= nv;
      buf_rx_data <= nv ? (32'h100 + rx_cnt + {31'h0, buf_rx_valid}) : ~buf_rx_data;
    end
  end
endmodule

// ===== test/fhd_dma_bench.sv
// Purpose: Self-checking bench for the host DMA engine
// Assumes: Partner model answers memory and buffer port
// Notes: ce tied high; word counts kept short
`timescale 1ns/10ps
module fhd_dma_bench;
  import fhd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  fhd_word_t host_addr = 32'h0;
  logic [7:0] host_wdata = 8'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic irq_a_n = 1'b1;
  logic irq_b_n = 1'b1;
  logic phy_n = 1'b1;
  logic rx_pending = 1'b0;
  logic frame_end = 1'b0;
  logic [7:0] host_rdata;
  logic [1:0] service_request_code;
  logic multicast_enable, host_irq, subsystem_reset_out, buf_rx_valid, buf_rx_ready, buf_tx_valid, buf_tx_ready;
  logic mem_req, mem_we, mem_gnt, mem_rvalid, rd_seen, pulsed;
  fhd_word_t buf_rx_data, buf_tx_data, mem_addr, mem_wdata, mem_rdata, a1, a2, a3;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] he;
  logic [64:0] me;
  logic [15:0] hq[$];
  logic [64:0] mq[$];
  fhd_word_t txq[$];
  always #5 sys_clk = ~sys_clk;
  fhd_dma uut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .controller_irq_line_a_n(irq_a_n),
    .controller_irq_line_b_n(irq_b_n), .phy_irq_line_n(phy_n), .rx_pending(rx_pending),
    .frame_end_signal(frame_end), .service_request_code(service_request_code),
    .multicast_enable(multicast_enable), .host_irq(host_irq), .subsystem_reset_out(subsystem_reset_out),
    .buf_rx_data(buf_rx_data), .buf_rx_valid(buf_rx_valid), .buf_rx_ready(buf_rx_ready),
    .buf_tx_data(buf_tx_data), .buf_tx_valid(buf_tx_valid), .buf_tx_ready(buf_tx_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid));
  fhd_partner u_far (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .buf_rx_data(buf_rx_data),
    .buf_rx_valid(buf_rx_valid), .buf_rx_ready(buf_rx_ready), .buf_tx_ready(buf_tx_ready));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input fhd_word_t seen, input fhd_word_t exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input fhd_word_t a, input logic [7:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
  endtask
  task automatic wr(input fhd_word_t a, input fhd_word_t d);
    for (int i = 0; i < 4; i++)
      wb(a + i, d[31 - 8 * i -: 8]);
    @(posedge sys_clk);
    host_wr <= 1'b0;
  endtask
  // Lane 0 first: it snapshots the word and fires side effects
  task automatic rd(input fhd_word_t a, input fhd_word_t e, input fhd_word_t m);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      host_addr <= a + i;
      host_rd <= 1'b1;
      hq.push_back({e[31 - 8 * i -: 8], m[31 - 8 * i -: 8]});
    end
    @(posedge sys_clk);
    host_rd <= 1'b0;
  endtask
  task automatic wait_code(input logic [1:0] c);
    for (int i = 0; i < 600 && service_request_code !== c; i++)
      @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    rd_seen <= host_rd;
    if (rd_seen === 1'b1)
    begin
      he = hq.pop_front();
      check({24'h0, host_rdata & he[7:0]}, {24'h0, he[15:8] & he[7:0]});
    end
    if (mem_req === 1'b1 && mem_gnt === 1'b1)
    begin
      me = mq.pop_front();
      check(mem_addr, me[63:32]);
      check({31'h0, mem_we}, {31'h0, me[64]});
      check(mem_we ? mem_wdata : 32'h0, me[31:0]);
    end
    if (buf_tx_valid === 1'b1 && buf_tx_ready === 1'b1)
      check(buf_tx_data, txq.pop_front());
    if (buf_rx_ready === 1'b1)
      check({30'h0, service_request_code}, 32'h2);
    if (cycles == 8000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    void'($urandom(99));
    a1 = $urandom & 32'h0FFFF000;
    a2 = $urandom & 32'h0FFFF000;
    a3 = $urandom & 32'h0FFFF000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(A_MASK, 32'h0, 32'h3F);
    rd(A_STAT, 32'h1, 32'h1);
    rd(A_CLAIM, 32'h2000, 32'hE000);
    rd(A_CTRL, 32'h2010, 32'hE070);
    wr(A_ADDR1, a1);
    wr(A_WC1, 32'h3);
    wr(A_ADDR2, a2);
    wr(A_WC2, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      me[63:32] = (i < 3) ? a1 + 4 * i : a2 + 4 * (i - 3);
      mq.push_back({1'b0, me[63:32], 32'h0});
      txq.push_back(me[63:32] ^ 32'hA5A50000);
    end
    wr(A_CTRL, 32'h13);
    repeat (2) @(posedge sys_clk);
    check({30'h0, service_request_code}, 32'h3);
    wait_code(REQ_NONE);
    repeat (20) @(posedge sys_clk);
    rd(A_STAT, 32'h1, 32'h1);
    rd(A_SUM, 32'h0, 32'hFFFFFFFF);
    wr(A_MASK, 32'h10);
    repeat (3) @(posedge sys_clk);
    check({31'h0, host_irq}, 32'h1);
    rd(A_CAUSE, 32'h10, 32'h10);
    rd(A_CAUSE, 32'h0, 32'h10);
    check({31'h0, host_irq}, 32'h0);
    wr(A_CTRL, 32'h0);
    wr(A_WC2, 32'h5);
    wr(A_ADDR1, a3);
    wr(A_WC1, 32'h4);
    wr(A_CTRL, 32'h4C);
    rd(A_WC2, 32'h0, 32'hFFF);
    for (int i = 0; i < 4; i++)
      mq.push_back({1'b1, a3 + 4 * i, 32'h100 + i});
    rx_pending <= 1'b1;
    wait_code(REQ_SYNC);
    check({30'h0, service_request_code}, 32'h2);
    rd(A_CLAIM, 32'hC000, 32'hE000);
    rd(A_CTRL, 32'hC020, 32'hE030);
    frame_end <= 1'b1;
    repeat (3) @(posedge sys_clk);
    frame_end <= 1'b0;
    wait_code(REQ_NONE);
    repeat (20) @(posedge sys_clk);
    rd(A_STAT, 32'h3, 32'h3);
    rd(A_SUM, 32'h406, 32'hFFFFFFFF);
    rd(A_STAT, 32'h0, 32'h2);
    rd(A_SUM, 32'h0, 32'hFFFFFFFF);
    irq_a_n <= 1'b0;
    phy_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(A_CAUSE, 32'hD, 32'hF);
    wr(A_MASK, 32'h21);
    repeat (3) @(posedge sys_clk);
    check({30'h0, multicast_enable, host_irq}, 32'h3);
    rd(32'hF8031340, 32'h0, 32'hFFFFFFFF);
    wb(A_SRST, 8'h00);
    @(posedge sys_clk);
    host_wr <= 1'b0;
    pulsed = 1'b0;
    repeat (4)
    begin
      @(posedge sys_clk);
      pulsed = pulsed | subsystem_reset_out;
    end
    check({31'h0, pulsed}, 32'h1);
    rd(A_MASK, 32'h0, 32'h3F);
    rd(A_CTRL, 32'h0, 32'h7F);
    repeat (10) @(posedge sys_clk);
    check(mq.size() + txq.size(), 32'h0);
    close_out();
  end
endmodule
